// ---- cre_pkg.sv ----
// Package of constants for the combined register and jump execution block
`default_nettype none
package cre_pkg;

    // Data and bus widths
    localparam int unsigned CRE_DW       = 16;
    localparam int unsigned CRE_AW       = 8;

    // Register byte offsets
    localparam logic [7:0] CRE_OFF_AREG  = 8'h00;
    localparam logic [7:0] CRE_OFF_BREG  = 8'h04;
    localparam logic [7:0] CRE_OFF_XREG  = 8'h08;
    localparam logic [7:0] CRE_OFF_PREG  = 8'h0c;
    localparam logic [7:0] CRE_OFF_WORD0 = 8'h10;
    localparam logic [7:0] CRE_OFF_WORD1 = 8'h14;
    localparam logic [7:0] CRE_OFF_EXEC  = 8'h18;
    localparam logic [7:0] CRE_OFF_STAT  = 8'h1c;

    // Status and exec register field positions
    localparam int unsigned CRE_ST_OVF   = 0;
    localparam int unsigned CRE_ST_SW_LO = 1;
    localparam int unsigned CRE_ST_TAKEN = 4;
    localparam int unsigned CRE_ST_ILL   = 5;
    localparam int unsigned CRE_EXEC_GO  = 0;

    // Instruction word fields
    localparam int unsigned CRE_OPC_LO   = 9;
    localparam int unsigned CRE_SUB_LO   = 6;
    localparam int unsigned CRE_SRC_LO   = 3;
    localparam int unsigned CRE_M_W      = 9;

    // Opcode patterns in bits 15..9
    localparam logic [6:0] CRE_OPC_JUMP  = 7'h01;
    localparam logic [6:0] CRE_OPC_COMB  = 7'h05;

    // Combined operation codes in bits 8..6
    localparam logic [2:0] CRE_SUB_MERGE = 3'h0;
    localparam logic [2:0] CRE_SUB_OR_INCREMENT_OP  = 3'h1;
    localparam logic [2:0] CRE_SUB_COMP  = 3'h2;
    localparam logic [2:0] CRE_SUB_OR_DECREMENT_OP  = 3'h3;

    // Register select bits of source and destination fields
    localparam int unsigned CRE_SEL_A    = 0;
    localparam int unsigned CRE_SEL_B    = 1;
    localparam int unsigned CRE_SEL_X    = 2;

    // Condition field bits and indexed jump codes
    localparam int unsigned CRE_M_OVF    = 0;
    localparam int unsigned CRE_M_SENSE1 = 1;
    localparam int unsigned CRE_M_SENSE2 = 2;
    localparam int unsigned CRE_M_AZ     = 3;
    localparam int unsigned CRE_M_BZ     = 4;
    localparam int unsigned CRE_M_XZ     = 5;
    localparam int unsigned CRE_M_SW1    = 6;
    localparam logic [8:0]  CRE_M_IDX_X  = 9'h005;
    localparam logic [8:0]  CRE_M_IDX_B  = 9'h006;

    // Arithmetic limits that set the overflow indicator
    localparam logic [15:0] CRE_MAX_POS  = 16'h7fff;
    localparam logic [15:0] CRE_MAX_NEG  = 16'h8000;

    // Reset values
    localparam logic [15:0] CRE_RST_WORD = 16'h0000;
    localparam logic [31:0] CRE_RST_RDAT = 32'h0000_0000;

    // Data phase kinds of the bus slave
    typedef enum logic [1:0] {CRE_DP_NONE, CRE_DP_WRITE, CRE_DP_READ} cre_dphase_e;

endpackage
`default_nettype wire

// ---- cre_exec.sv ----
// Combined register operations and two-word jump execution behind an AHB-Lite slave
//
// Operation
// - Source bits 3-5 pick A, B, X; set bits OR them; 000 gives zero.
// - Destination bits 0-2 pick A, B, X to write; 000 writes nothing.
// - Merge writes OR of sources into every selected destination.
// - Decrement writes source OR minus one into selected destinations.
// - Complement writes inverted source OR into selected destinations.
// - Clear loads zero into every selected destination.
// - Jumps take two words: opcode 9-15, condition 0-8, then address.
// - Jump group recognised when bits 9-15 equal 0000001.
// - All-zero condition field jumps unconditionally.
// - Each condition bit except 1 and 2 tests one item; only set bits are tested.
// - Bit 1 or 2 clear: item passes when set or register zero.
// - Bits 1 and 2 set: item passes when clear or register nonzero.
// - Only bit 1 set: jump when A bit 15 clear; B, X untouched.
// - Only bit 2 set: jump when A bit 15 set.
// - Condition met: program counter loads the jump address.
// - Condition failed: continue after the second instruction word.
// - Indexed jump adds index register to address, jumps unconditionally.
// - Indexed jump: 101 selects X, 110 selects B as index.
// - Overflow-clear test jumps when overflow clear, falls through when set.
// - Code 002 jumps when A positive or zero.
// - Code 004 jumps when A negative.
// - Code 040 jumps when X is zero.
// - Code 016 jumps on A nonzero, 046 on X nonzero.
`timescale 1ns/1ps
`default_nettype none
module cre_exec
    import cre_pkg::*;
#(
    parameter int unsigned DW = cre_pkg::CRE_DW
)
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    input  wire logic [2:0]        sense_sw,
    output var  logic [31:0]       hrdata,
    output var  logic              hreadyout,
    output var  logic              hresp,
    output var  logic              exec_done,
    output var  logic              jump_taken
);
    import cre_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Field positions assume a 16-bit word; narrower words lose the opcode
    if (DW != CRE_DW)
    begin : g_width_check
        $error("cre_exec: DW must be 16");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DW-1:0]  areg;
        logic [DW-1:0]  breg;
        logic [DW-1:0]  xreg;
        logic [DW-1:0]  preg;
        logic [DW-1:0]  word0;
        logic [DW-1:0]  word1;
        logic           ovf;
        logic           taken;
        logic           illegal;
        logic           done;
        cre_dphase_e    dphase;
        logic [7:0]     daddr;
        logic [31:0]    rdata;
        logic           readyout;
    } cre_state_s;

    cre_state_s st_ff;
    cre_state_s nxt_st;

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    logic [6:0]      opc;
    logic [2:0]      sub;
    logic [2:0]      src_sel;
    logic [2:0]      dst_sel;
    logic [8:0]      mfield;
    logic            is_jump;
    logic            is_comb;

    // Fields of the first word; second word is the jump address
    assign opc     = st_ff.word0[15:CRE_OPC_LO];
    assign sub     = st_ff.word0[8:CRE_SUB_LO];
    assign src_sel = st_ff.word0[5:CRE_SRC_LO];
    assign dst_sel = st_ff.word0[2:0];
    assign mfield  = st_ff.word0[CRE_M_W-1:0];
    assign is_jump = (opc == CRE_OPC_JUMP);
    assign is_comb = (opc == CRE_OPC_COMB);

    // ------------------------------------------------------------
    // Combined register operation datapath
    // ------------------------------------------------------------
    logic [DW-1:0]   src_or;
    logic [DW-1:0]   comb_res;
    logic            comb_ok;
    logic            comb_ovf;

    // Source OR; an empty selection yields zero, which is how clear works
    assign src_or = ({DW{src_sel[CRE_SEL_A]}} & st_ff.areg)
                  | ({DW{src_sel[CRE_SEL_B]}} & st_ff.breg)
                  | ({DW{src_sel[CRE_SEL_X]}} & st_ff.xreg);

    // Operation select; overflow-conditional variants are not executed here
    // Trade-off: they would need a second decode, so their codes are refused
    always_comb
    begin
        comb_res = src_or;
        comb_ok  = 1'b1;
        comb_ovf = st_ff.ovf;
        unique case (sub)
            CRE_SUB_MERGE:
            begin
                comb_res = src_or;
            end
            CRE_SUB_OR_INCREMENT_OP:
            begin
                comb_res = DW'(src_or + 1'b1);
                comb_ovf = st_ff.ovf | (src_or == CRE_MAX_POS);
            end
            CRE_SUB_COMP:
            begin
                comb_res = ~src_or;
            end
            CRE_SUB_OR_DECREMENT_OP:
            begin
                comb_res = DW'(src_or - 1'b1);
                comb_ovf = st_ff.ovf | (src_or == CRE_MAX_NEG);
            end
            default:
            begin
                comb_ok  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Jump condition evaluation
    // ------------------------------------------------------------
    logic [8:0]      item_val;
    logic [8:0]      item_pass;
    logic            sense_inv;
    logic            only_pos;
    logic            only_neg;
    logic            sign_ok;
    logic            cond_met;
    logic            is_index;
    logic [DW-1:0]   index_val;
    logic [DW-1:0]   jump_target;

    // Raw item states; bits 1 and 2 carry the sense, not an item
    // Switch items are level samples of the execute cycle; no latching
    always_comb
    begin
        item_val                 = 9'h000;
        item_val[CRE_M_OVF]      = st_ff.ovf;
        item_val[CRE_M_AZ]       = (st_ff.areg == '0);
        item_val[CRE_M_BZ]       = (st_ff.breg == '0);
        item_val[CRE_M_XZ]       = (st_ff.xreg == '0);
        item_val[8:CRE_M_SW1]    = sense_sw;
    end

    // Both sense bits set inverts every test
    assign sense_inv = mfield[CRE_M_SENSE1] & mfield[CRE_M_SENSE2];
    assign only_pos  = mfield[CRE_M_SENSE1] & ~mfield[CRE_M_SENSE2];
    assign only_neg  = ~mfield[CRE_M_SENSE1] & mfield[CRE_M_SENSE2];

    // Per-item pass; an item whose bit is clear is not examined
    // Sense bits always pass; they only steer the other tests
    genvar gi;
    for (gi = 0; gi < CRE_M_W; gi = gi + 1)
    begin : g_item
        if (gi == CRE_M_SENSE1 || gi == CRE_M_SENSE2)
        begin : g_sense
            assign item_pass[gi] = 1'b1;
        end
        else
        begin : g_test
            assign item_pass[gi] = ~mfield[gi]
                                 | (sense_inv ? ~item_val[gi] : item_val[gi]);
        end
    end

    // Lone sense bit tests the sign of A only
    assign sign_ok = only_pos ? ~st_ff.areg[DW-1]
                   : only_neg ?  st_ff.areg[DW-1]
                   : 1'b1;

    // Empty field passes trivially, giving the unconditional jump
    assign cond_met = (mfield == 9'h000) | (sign_ok & (&item_pass));

    // Indexed jump codes take priority over the same bits read as tests
    // Target addition wraps at the word size, like the program counter
    assign is_index    = (mfield == CRE_M_IDX_X) | (mfield == CRE_M_IDX_B);
    assign index_val   = (mfield == CRE_M_IDX_X) ? st_ff.xreg : st_ff.breg;
    assign jump_target = is_index ? DW'(st_ff.word1 + index_val) : st_ff.word1;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic            addr_valid;
    logic            exec_go;

    // Address phase accepted on a NONSEQ or SEQ transfer with the bus ready
    assign addr_valid = hsel & hready & htrans[1];
    // Execution launches in the data phase of a write to the exec register
    // hwdata is read live here, with no copy, so the instruction held at
    // that edge is the one that runs
    assign exec_go    = (st_ff.dphase == CRE_DP_WRITE) & (st_ff.daddr == CRE_OFF_EXEC)
                      & hwdata[CRE_EXEC_GO];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus writes go first and execution after, so an execute wins over a
    // status write that lands in the same cycle
    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.done     = 1'b0;
        nxt_st.readyout = 1'b1;

        // Software write of the data phase
        if (st_ff.dphase == CRE_DP_WRITE)
        begin
            unique case (st_ff.daddr)
                CRE_OFF_AREG:  nxt_st.areg  = hwdata[DW-1:0];
                CRE_OFF_BREG:  nxt_st.breg  = hwdata[DW-1:0];
                CRE_OFF_XREG:  nxt_st.xreg  = hwdata[DW-1:0];
                CRE_OFF_PREG:  nxt_st.preg  = hwdata[DW-1:0];
                CRE_OFF_WORD0: nxt_st.word0 = hwdata[DW-1:0];
                CRE_OFF_WORD1: nxt_st.word1 = hwdata[DW-1:0];
                CRE_OFF_STAT:  nxt_st.ovf   = hwdata[CRE_ST_OVF];
                default:       nxt_st.ovf   = st_ff.ovf;
            endcase
        end

        // One-cycle execution of the held instruction
        if (exec_go)
        begin
            nxt_st.done    = 1'b1;
            nxt_st.illegal = 1'b0;
            if (is_jump)
            begin
                nxt_st.taken = is_index | cond_met;
                if (is_index | cond_met)
                begin
                    nxt_st.preg = jump_target;
                end
                else
                begin
                    nxt_st.preg = DW'(st_ff.preg + 2'd2);
                end
            end
            else if (is_comb && comb_ok)
            begin
                nxt_st.taken = 1'b0;
                nxt_st.ovf   = comb_ovf;
                // Every selected destination gets the same result
                if (dst_sel[CRE_SEL_A])
                begin
                    nxt_st.areg = comb_res;
                end
                if (dst_sel[CRE_SEL_B])
                begin
                    nxt_st.breg = comb_res;
                end
                if (dst_sel[CRE_SEL_X])
                begin
                    nxt_st.xreg = comb_res;
                end
                nxt_st.preg = DW'(st_ff.preg + 1'b1);
            end
            else
            begin
                // Unknown word leaves every register alone and is flagged
                nxt_st.taken   = 1'b0;
                nxt_st.illegal = 1'b1;
            end
        end

        // Address phase; read data taken from the updated copy so reads never lag
        // Unaligned or unmapped offsets read as zero through the default arm
        nxt_st.dphase = CRE_DP_NONE;
        if (addr_valid)
        begin
            nxt_st.daddr  = haddr[7:0];
            nxt_st.dphase = hwrite ? CRE_DP_WRITE : CRE_DP_READ;
            nxt_st.rdata  = CRE_RST_RDAT;
            if (!hwrite && haddr[31:8] == '0)
            begin
                unique case (haddr[7:0])
                    CRE_OFF_AREG:  nxt_st.rdata[DW-1:0] = nxt_st.areg;
                    CRE_OFF_BREG:  nxt_st.rdata[DW-1:0] = nxt_st.breg;
                    CRE_OFF_XREG:  nxt_st.rdata[DW-1:0] = nxt_st.xreg;
                    CRE_OFF_PREG:  nxt_st.rdata[DW-1:0] = nxt_st.preg;
                    CRE_OFF_WORD0: nxt_st.rdata[DW-1:0] = nxt_st.word0;
                    CRE_OFF_WORD1: nxt_st.rdata[DW-1:0] = nxt_st.word1;
                    CRE_OFF_STAT:
                    begin
                        nxt_st.rdata[CRE_ST_OVF]              = nxt_st.ovf;
                        nxt_st.rdata[CRE_ST_SW_LO+2:CRE_ST_SW_LO] = sense_sw;
                        nxt_st.rdata[CRE_ST_TAKEN]            = nxt_st.taken;
                        nxt_st.rdata[CRE_ST_ILL]              = nxt_st.illegal;
                    end
                    default:       nxt_st.rdata = CRE_RST_RDAT;
                endcase
            end
            if (haddr[31:8] != '0)
            begin
                // Out-of-range writes fall into the unmapped default
                nxt_st.daddr = 8'hff;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff.areg     <= CRE_RST_WORD;
            st_ff.breg     <= CRE_RST_WORD;
            st_ff.xreg     <= CRE_RST_WORD;
            st_ff.preg     <= CRE_RST_WORD;
            st_ff.word0    <= CRE_RST_WORD;
            st_ff.word1    <= CRE_RST_WORD;
            st_ff.ovf      <= 1'b0;
            st_ff.taken    <= 1'b0;
            st_ff.illegal  <= 1'b0;
            st_ff.done     <= 1'b0;
            st_ff.dphase   <= CRE_DP_NONE;
            st_ff.daddr    <= 8'h00;
            st_ff.rdata    <= CRE_RST_RDAT;
            st_ff.readyout <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all but the tied-off hresp straight from the state register
    // ------------------------------------------------------------
    // Slave never inserts wait states and never signals an error
    // The response is a tie-off, since no request is ever refused
    assign hrdata     = st_ff.rdata;
    assign hreadyout  = st_ff.readyout;
    assign hresp      = 1'b0;
    assign exec_done  = st_ff.done;
    assign jump_taken = st_ff.taken;

endmodule
`default_nettype wire

// ---- cre_exec_checker.sv ----
// Assertion checker watching the ports of the execution block
`timescale 1ns/1ps
`default_nettype none
module cre_exec_checker
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [2:0]  sense_sw,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        exec_done,
    input wire logic        jump_taken
);
    // ------------------
    // Bus phase tracking
    // ------------------
    logic        ap_ff;
    logic        apw_ff;
    logic [31:0] apa_ff;
    logic [15:0] w0_ff;
    logic        ex;

    // Latch the accepted address phase and the last first word written
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_ff  <= 1'b0;
            apw_ff <= 1'b0;
            apa_ff <= 32'h0;
            w0_ff  <= 16'h0;
        end
        else
        begin
            if (hready)
            begin
                ap_ff  <= hsel & htrans[1];
                apw_ff <= hwrite;
                apa_ff <= haddr;
            end
            if (ap_ff && apw_ff && apa_ff == 32'h10)
                w0_ff <= hwdata[15:0];
        end
    end

    // Execute strobe, true in the data phase of a go write
    assign ex = ap_ff & apw_ff & (apa_ff == 32'h18) & hwdata[0];

    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    done_after_exec_a: assert property (ex |=> exec_done)
        else $error("no done pulse after an execute");
    done_cause_a: assert property (exec_done |-> $past(ex))
        else $error("done pulse without an execute");
    taken_stable_a: assert property ($past(hresetn) && $changed(jump_taken) |-> exec_done)
        else $error("jump flag moved outside an execute");
    uncond_jump_a: assert property (ex && w0_ff == 16'h0200 |=> jump_taken)
        else $error("unconditional jump not taken");
    indexed_jump_a: assert property (ex && w0_ff inside {16'h0205, 16'h0206} |=> jump_taken)
        else $error("indexed jump not taken");
    comb_no_jump_a: assert property (ex && w0_ff[15:9] == 7'h05 && !w0_ff[8] |=> !jump_taken)
        else $error("register operation flagged as jump");
    sense_set_a: assert property (ex && w0_ff == 16'h0240 |=> jump_taken == $past(sense_sw[0]))
        else $error("switch set test wrong");
    sense_clear_a: assert property (ex && w0_ff == 16'h0246 |=> jump_taken != $past(sense_sw[0]))
        else $error("switch clear test wrong");
    unmapped_zero_a: assert property (ap_ff && !apw_ff && (apa_ff[31:8] != 24'h0 || apa_ff == 32'h18)
        |-> hrdata == 32'h0)
        else $error("unmapped or go read not zero");
    bus_okay_a: assert property (hresp == 1'b0 && hreadyout)
        else $error("bus response not okay and ready");
endmodule

bind cre_exec cre_exec_checker cre_exec_checker_i (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hready),
    .sense_sw   (sense_sw),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .exec_done  (exec_done),
    .jump_taken (jump_taken)
);
`default_nettype wire

// ---- cre_exec_test.sv ----
// Self-checking testbench for the execution block
`timescale 1ns/1ps
`default_nettype none
module cre_exec_test;
    import cre_pkg::*;

    // -----------------
    // Signals and model
    // -----------------
    localparam logic [8:0] OFS_ST = {1'b0, CRE_OFF_STAT};
    localparam logic [8:0] OFS_W0 = {1'b0, CRE_OFF_WORD0};
    localparam logic [8:0] OFS_W1 = {1'b0, CRE_OFF_WORD1};
    localparam logic [8:0] OFS_EX = {1'b0, CRE_OFF_EXEC};
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [2:0]  sense_sw;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        exec_done;
    logic        jump_taken;
    logic        rd_chk;
    int          errors;
    int          tests_run;
    int          seed;
    logic [15:0] rg [4];
    logic        ovf;
    logic        jt;
    logic        ill;
    logic [24:0] note;
    logic [24:0] exp_q [$];
    logic [8:0]  codes [16] = '{9'h000, 9'h002, 9'h004, 9'h020, 9'h00e, 9'h026, 9'h007, 9'h001,
                                9'h040, 9'h046, 9'h080, 9'h100, 9'h010, 9'h008, 9'h005, 9'h006};

    // Free-running bus clock
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    cre_exec cre_exec_i (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (3'b010),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .sense_sw   (sense_sw),
        .hrdata     (hrdata),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .exec_done  (exec_done),
        .jump_taken (jump_taken)
    );

    // ---------------
    // Bus and checks
    // ---------------
    // One single transfer; address held until ready, data held until ready
    task automatic xfer(input logic w, input logic [8:0] o, input logic [15:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {23'h0, o};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= {16'h0, d};
        rd_chk <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_chk <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] o, input logic [15:0] d);
        xfer(1'b1, o, d);
    endtask

    task automatic rd(input logic [8:0] o, input logic [15:0] e);
        exp_q.push_back({o, e});
        xfer(1'b0, o, 16'h0);
    endtask

    task automatic exec_ins(input logic [15:0] w0, input logic [15:0] w1);
        wr(OFS_W0, w0);
        wr(OFS_W1, w1);
        wr(OFS_EX, 16'h1);
    endtask

    task automatic load_regs();
        for (int k = 0; k < 4; k++)
            wr(9'(k * 4), rg[k]);
        wr(OFS_ST, {15'h0, ovf});
    endtask

    task automatic check_all();
        for (int k = 0; k < 4; k++)
            rd(9'(k * 4), rg[k]);
        rd(OFS_ST, {10'h0, ill, jt, sense_sw, ovf});
    endtask

    // Read data is judged at the edge that ends its data phase
    always @(posedge hclk)
    begin
        if (rd_chk && hreadyout === 1'b1)
        begin
            note = exp_q.pop_front();
            tests_run++;
            if (hrdata !== {16'h0, note[15:0]})
            begin
                errors++;
                $display("BAD reg %h exp %h got %h", note[24:16], note[15:0], hrdata);
            end
        end
    end

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rg = '{default: 16'h0};
        ovf = 1'b0;
        jt = 1'b0;
        ill = 1'b0;
    endtask

    // ---------
    // Scenarios
    // ---------
    // Every operation code, boundary values that wrap, empty source and destination
    task automatic comb_test();
        logic [2:0]  sub;
        logic [2:0]  src;
        logic [2:0]  dst;
        logic [15:0] s;
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
        begin
            for (int k = 0; k < 4; k++)
                rg[k] = 16'($random(seed));
            rg[0] = (i == 1) ? 16'h7fff : (i == 3) ? 16'h8000 : rg[0];
            ovf = (i < 4) ? 1'b0 : 1'($random(seed));
            sense_sw <= 3'($random(seed));
            sub = 3'(i % 4);
            src = (i == 4) ? 3'h0 : (i < 4) ? 3'h1 : 3'($random(seed));
            dst = 3'($random(seed));
            load_regs();
            s = (src[0] ? rg[0] : 16'h0) | (src[1] ? rg[1] : 16'h0) | (src[2] ? rg[2] : 16'h0);
            case (sub)
                3'h0: r = s;
                3'h1: r = s + 16'h1;
                3'h2: r = ~s;
                default: r = s - 16'h1;
            endcase
            ovf = ovf | (sub == 3'h1 && s == 16'h7fff) | (sub == 3'h3 && s == 16'h8000);
            exec_ins({7'h05, sub, src, dst}, 16'h0);
            for (int k = 0; k < 3; k++)
                if (dst[k])
                    rg[k] = r;
            rg[3] = rg[3] + 16'h1;
            jt = 1'b0;
            check_all();
        end
    endtask

    // Each condition code twice, registers often zero so both outcomes occur
    task automatic jump_test();
        logic [8:0]  m;
        logic [8:0]  item;
        logic [15:0] w1;
        logic [15:0] ix;
        logic        go;
        for (int i = 0; i < 32; i++)
        begin
            m = codes[i % 16];
            for (int k = 0; k < 3; k++)
                rg[k] = 1'($random(seed)) ? 16'h0 : 16'($random(seed));
            rg[3] = 16'($random(seed));
            ovf = 1'($random(seed));
            w1 = 16'($random(seed));
            sense_sw <= 3'($random(seed));
            load_regs();
            item = {sense_sw, rg[2] == 16'h0, rg[1] == 16'h0, rg[0] == 16'h0, 2'b00, ovf};
            go = ((item ^ {9{m[1] & m[2]}}) & m & 9'h1f9) == (m & 9'h1f9);
            if (m[1] != m[2])
                go = go & (rg[0][15] == m[2]);
            ix = (m == 9'h005) ? rg[2] : (m == 9'h006) ? rg[1] : 16'h0;
            go = go | (m == 9'h005) | (m == 9'h006);
            exec_ins({7'h01, m}, w1);
            rg[3] = go ? w1 + ix : rg[3] + 16'h2;
            jt = go;
            check_all();
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Roughly 650 transfers of two cycles each; this span leaves wide margin
    initial
    begin
        repeat (20000) @(posedge hclk);
        errors++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        sense_sw = 3'h0;
        rd_chk = 1'b0;
        errors = 0;
        tests_run = 0;
        seed = 32'h7fcb;
        do_reset();
        check_all();
        $display("test reset values done");
        comb_test();
        $display("test register operations done");
        jump_test();
        $display("test jumps done");
        rd(9'h100, 16'h0);
        rd(OFS_EX, 16'h0);
        wr(9'h100, 16'hffff);
        check_all();
        exec_ins(16'h0400, 16'h1234);
        ill = 1'b1;
        jt = 1'b0;
        check_all();
        exec_ins({7'h05, 3'h4, 6'h09}, 16'h0);
        check_all();
        do_reset();
        check_all();
        $display("test refusals and second reset done");
        @(posedge hclk);
        end_of_test();
    end
endmodule
`default_nettype wire
